// ==== verilog/dram_ctrl_pkg.sv ====
/*
 * Constants, timing figures and the state type for the host-side controller
 * of a 1M x 36 multiplexed-address DRAM module.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 */
// Notes on behaviour
// - Every one of 1024 rows gets a row strobe within each 16 ms.
// - Refresh row counter puts its most significant, slowest bit on A9.
// - All combinations of A0-A8 are refreshed at least every 8 ms.
// - Refresh keeps all column strobes high and cycles only row strobes.
// - Only early writes: write strobe low before any column strobe falls.
`default_nettype none
package dram_ctrl_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W     = 20;
    localparam int unsigned MUX_W      = 10;
    localparam int unsigned LANES      = 4;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ROWS       = 1024;
    localparam int unsigned ROW_LSB    = 10;
    localparam int unsigned COL_LSB    = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ    = 100;
    localparam int unsigned CLK_NS     = 1000 / CLK_MHZ;
    localparam int unsigned REF_MS     = 16;
    localparam int unsigned PAR_REF_MS = 8;
    // The 8 ms limit on A0-A8 dominates; a margin of two is kept, so all
    // 1024 rows come round in about 4 ms.
    localparam int unsigned REF_INT_CYC =
        (PAR_REF_MS * 1000 * CLK_MHZ * 1000) / (2 * ROWS * 1000);
    localparam int unsigned T_RP_NS    = 60;
    localparam int unsigned T_RCD_NS   = 30;
    localparam int unsigned T_CAS_NS   = 30;
    localparam int unsigned T_RAS_NS   = 80;
    localparam int unsigned RP_CYC  = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  STROBES_IDLE = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RAS, ST_CAS, ST_REF, ST_PRE
    } ctrl_state_t;
endpackage
`default_nettype wire

// ==== verilog/refresh_timer.sv ====
/*
 * Refresh request timer and row counter.
 * Assumes the controller acknowledges each request with one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module refresh_timer
    import dram_ctrl_pkg::*;
#(
    parameter int unsigned INTERVAL = REF_INT_CYC
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             nrst_i,
    // Handshake
    input  wire logic             done_i,
    output logic                  req_o,
    output logic [MUX_W-1:0]      row_o
);
    logic [15:0]      cnt_q;
    logic [MUX_W-1:0] row_q;
    logic             req_q;
    wire              tick = (cnt_q == 16'(INTERVAL - 1));

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cnt_q <= 16'h0000;
            req_q <= 1'b0;
            row_q <= '0;
        end else begin
            cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
            // A new tick wins over a simultaneous acknowledge.
            req_q <= tick | (req_q & ~done_i);
            // Plain binary count: A9 is the MSB and toggles slowest.
            if (done_i) begin
                row_q <= row_q + MUX_W'(1);
            end
        end
    end
    assign req_o = req_q;
    assign row_o = row_q;
endmodule
`default_nettype wire

// ==== verilog/dram_ctrl.sv ====
/*
 * Host controller driving a 1M x 36 DRAM module over its strobes.
 * Assumes the module's pins are wired to these ports and the outside world
 * resolves the shared data and parity wires from the output enables.
 */
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl
    import dram_ctrl_pkg::*;
#(
    parameter int unsigned REF_INTERVAL = REF_INT_CYC
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 nrst_i,
    // User request
    input  wire logic                 req_i,
    input  wire logic                 we_i,
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic [LANES-1:0]     lane_en_i,
    input  wire logic [DATA_W-1:0]    wdata_i,
    input  wire logic [LANES-1:0]     wpar_i,
    output logic                      ready_o,
    output logic                      rvalid_o,
    output logic [DATA_W-1:0]         rdata_o,
    output logic [LANES-1:0]          rpar_o,
    // Module pins
    output logic                      row_strobe_lower_half_n_o,
    output logic                      row_strobe_upper_half_n_o,
    output logic [LANES-1:0]          lane_column_strobes_n_o,
    output logic                      write_strobe_n_o,
    output logic [MUX_W-1:0]          multiplexed_addr_lines_o,
    input  wire logic [DATA_W-1:0]    shared_data_lines_i,
    output logic [DATA_W-1:0]         shared_data_lines_o,
    output logic [LANES-1:0]          shared_data_lines_oe_o,
    input  wire logic [LANES-1:0]     lane_parity_lines_i,
    output logic [LANES-1:0]          lane_parity_lines_o,
    output logic [LANES-1:0]          lane_parity_lines_oe_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ctrl_state_t       state_q;
    logic [7:0]        cnt_q;
    logic              we_q;
    logic [LANES-1:0]  lanes_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q, rdata_q, dq_s1_q, dq_s2_q;
    logic [LANES-1:0]  wpar_q, rpar_q, mp_s1_q, mp_s2_q;
    logic              rvalid_q, ras_lo_q, ras_hi_q, we_n_q;
    logic [LANES-1:0]  cas_n_q;
    logic [MUX_W-1:0]  ma_q;
    logic              ref_req, ref_done;
    logic [MUX_W-1:0]  ref_row;

    refresh_timer #(.INTERVAL(REF_INTERVAL)) u_ref (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .done_i    (ref_done),
        .req_o     (ref_req),
        .row_o     (ref_row)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire cnt_end = (cnt_q == 8'h00);
    // Lanes 0-1 need the lower row strobe, lanes 2-3 the upper one.
    wire need_lo = |lane_en_i[1:0];
    wire need_hi = |lane_en_i[3:2];
    assign ready_o  = (state_q == ST_IDLE) && !ref_req;
    assign ref_done = (state_q == ST_REF) && cnt_end;
    wire start = ready_o && req_i && (lane_en_i != STROBES_IDLE);

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q  <= ST_IDLE;
            cnt_q    <= 8'h00;
            we_q     <= 1'b0;
            lanes_q  <= 4'h0;
            addr_q   <= 20'h0_0000;
            wdata_q  <= 32'h0000_0000;
            wpar_q   <= 4'h0;
            ras_lo_q <= 1'b1;
            ras_hi_q <= 1'b1;
            cas_n_q  <= 4'hF;
            we_n_q   <= 1'b1;
            ma_q     <= 10'h000;
        end else begin
            cnt_q <= cnt_end ? 8'h00 : cnt_q - 8'h01;
            unique case (state_q)
                ST_IDLE: begin
                    if (ref_req) begin
                        // Row-only refresh; column strobes stay high.
                        ma_q     <= ref_row;
                        ras_lo_q <= 1'b0;
                        ras_hi_q <= 1'b0;
                        cnt_q    <= 8'(RAS_CYC - 1);
                        state_q  <= ST_REF;
                    end else if (start) begin
                        we_q     <= we_i;
                        lanes_q  <= lane_en_i;
                        addr_q   <= addr_i;
                        wdata_q  <= wdata_i;
                        wpar_q   <= wpar_i;
                        ma_q     <= addr_i[ROW_LSB +: MUX_W];
                        ras_lo_q <= ~need_lo;
                        ras_hi_q <= ~need_hi;
                        cnt_q    <= 8'(RCD_CYC - 1);
                        state_q  <= ST_RAS;
                    end
                end
                ST_RAS: begin
                    if (cnt_end) begin
                        ma_q    <= addr_q[COL_LSB +: MUX_W];
                        // Write strobe falls one cycle before columns.
                        we_n_q  <= ~we_q;
                        cnt_q   <= 8'(CAS_CYC);
                        state_q <= ST_CAS;
                    end
                end
                ST_CAS: begin
                    if (cnt_q == 8'(CAS_CYC)) begin
                        cas_n_q <= ~lanes_q;
                    end
                    if (cnt_end) begin
                        cas_n_q  <= 4'hF;
                        ras_lo_q <= 1'b1;
                        ras_hi_q <= 1'b1;
                        we_n_q   <= 1'b1;
                        cnt_q    <= 8'(RP_CYC - 1);
                        state_q  <= ST_PRE;
                    end
                end
                ST_REF: begin
                    if (cnt_end) begin
                        ras_lo_q <= 1'b1;
                        ras_hi_q <= 1'b1;
                        cnt_q    <= 8'(RP_CYC - 1);
                        state_q  <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (cnt_end) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read capture through two flip-flops; all four lanes taken whole at the last column cycle.
    // ------------------------------------------------------------------
    wire cas_last = (state_q == ST_CAS) && cnt_end;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            dq_s1_q  <= 32'h0000_0000;
            dq_s2_q  <= 32'h0000_0000;
            mp_s1_q  <= 4'h0;
            mp_s2_q  <= 4'h0;
            rdata_q  <= 32'h0000_0000;
            rpar_q   <= 4'h0;
            rvalid_q <= 1'b0;
        end else begin
            dq_s1_q  <= shared_data_lines_i;
            dq_s2_q  <= dq_s1_q;
            mp_s1_q  <= lane_parity_lines_i;
            mp_s2_q  <= mp_s1_q;
            rvalid_q <= cas_last && !we_q;
            if (cas_last && !we_q) begin
                rdata_q <= dq_s2_q;
                rpar_q  <= mp_s2_q;
            end
        end
    end

    // Drive data only while writing, so the shared lines never collide.
    wire [LANES-1:0] wr_oe = (we_q && state_q == ST_CAS && !we_n_q) ?
                             lanes_q : 4'h0;
    assign shared_data_lines_oe_o    = wr_oe;
    assign lane_parity_lines_oe_o    = wr_oe;
    assign shared_data_lines_o       = wdata_q;
    assign lane_parity_lines_o       = wpar_q;
    assign row_strobe_lower_half_n_o = ras_lo_q;
    assign row_strobe_upper_half_n_o = ras_hi_q;
    assign lane_column_strobes_n_o   = cas_n_q;
    assign write_strobe_n_o          = we_n_q;
    assign multiplexed_addr_lines_o  = ma_q;
    assign rvalid_o                  = rvalid_q;
    assign rdata_o                   = rdata_q;
    assign rpar_o                    = rpar_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_early_write;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        ($rose(|(~cas_n_q)) && we_q) |-> (!we_n_q && !$past(we_n_q));
    endproperty
    a_early_write: assert property (p_early_write)
        else $error("column strobe fell before write strobe");

    property p_refresh_no_cas;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state_q == ST_REF) |-> (cas_n_q == 4'hF);
    endproperty
    a_refresh_no_cas: assert property (p_refresh_no_cas)
        else $error("column strobe active during refresh");

    property p_refresh_both_rows;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state_q == ST_IDLE && ref_req) |=> (!ras_lo_q && !ras_hi_q);
    endproperty
    a_refresh_both_rows: assert property (p_refresh_both_rows)
        else $error("refresh did not strobe both row halves");

    property p_row_advance;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        ref_done |=> (ref_row == $past(ref_row) + 10'h001);
    endproperty
    a_row_advance: assert property (p_row_advance)
        else $error("refresh row did not advance");

    property p_req_served;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(ref_req) |-> ##[1:40] ref_done;
    endproperty
    a_req_served: assert property (p_req_served)
        else $error("refresh request not served in time");

    property p_lane_row;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (!cas_n_q[0] || !cas_n_q[1]) |-> !ras_lo_q;
    endproperty
    a_lane_row: assert property (p_lane_row)
        else $error("lower lane strobed without its row strobe");

    property p_oe_write_only;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (shared_data_lines_oe_o != 4'h0) |-> (we_q && !we_n_q);
    endproperty
    a_oe_write_only: assert property (p_oe_write_only)
        else $error("data driven outside a write");

    sequence s_row_phase;
        (state_q == ST_RAS) && cnt_end;
    endsequence
    property p_col_addr;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_row_phase |=> (ma_q == addr_q[COL_LSB +: MUX_W]);
    endproperty
    a_col_addr: assert property (p_col_addr)
        else $error("column address not presented");

    property p_lane_gate;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state_q == ST_CAS) |-> ((~cas_n_q & ~lanes_q) == 4'h0);
    endproperty
    a_lane_gate: assert property (p_lane_gate)
        else $error("column strobe on unrequested lane");
endmodule
`default_nettype wire

// ==== test/dram_module_model.sv ====
/*
 * Behavioural model of the 1M x 36 DRAM module seen from its pins.
 * Assumes the controller's registered strobes; it samples 1 ns after each falling
 * row or column strobe edge and resolves the shared data and parity wires itself.
 */
`timescale 1ns/1ps
`default_nettype none
module dram_module_model
    import dram_ctrl_pkg::*;
(
    // Strobes and address
    input  wire logic              row_lo_n_i,
    input  wire logic              row_hi_n_i,
    input  wire logic [LANES-1:0]  col_n_i,
    input  wire logic              wr_n_i,
    input  wire logic [MUX_W-1:0]  addr_i,
    // Controller side of the shared wires
    input  wire logic [DATA_W-1:0] dq_i,
    input  wire logic [LANES-1:0]  dq_oe_i,
    input  wire logic [LANES-1:0]  par_i,
    input  wire logic [LANES-1:0]  par_oe_i,
    // Resolved wires and findings
    output logic [DATA_W-1:0]      dq_o,
    output logic [LANES-1:0]       par_o,
    output var int                 viol_o,
    output var int                 nref_o,
    output var int                 max_gap_o
);
    // ------------------------------------------------------------------
    // Storage and row capture
    // ------------------------------------------------------------------
    logic [8:0]       mem [int];
    time              t_ref [int];
    logic [MUX_W-1:0] row_q [2];
    logic [MUX_W-1:0] last_q;
    logic             col_seen;
    initial begin
        viol_o = 0;
        nref_o = 0;
        max_gap_o = 0;
        // Set so that the first rise of the row strobe out of reset is not
        // mistaken for a refresh.
        col_seen = 1'b1;
    end
    // Cleared at each lower row cycle, so an upper-only access before it
    // cannot hide the refresh that follows.
    always @(negedge row_lo_n_i) begin
        col_seen = 1'b0;
        #1 row_q[0] = addr_i;
    end
    always @(negedge row_hi_n_i) begin
        #1 row_q[1] = addr_i;
    end
    // A row cycle without any column strobe is a refresh of that row.
    always @(posedge row_lo_n_i) begin
        if (!col_seen) begin
            if (nref_o > 0 && row_q[0] !== MUX_W'(last_q + 1))
                viol_o++;
            if (t_ref.exists(int'(row_q[0])) &&
                int'($time - t_ref[int'(row_q[0])]) > max_gap_o)
                max_gap_o = int'($time - t_ref[int'(row_q[0])]);
            t_ref[int'(row_q[0])] = $time;
            last_q = row_q[0];
            nref_o++;
        end
        col_seen = 1'b0;
    end
    // Write strobe may only fall while every column strobe is high.
    always @(negedge wr_n_i) begin
        if (!(&col_n_i))
            viol_o++;
    end
    // ------------------------------------------------------------------
    // Lanes
    // ------------------------------------------------------------------
    for (genvar n = 0; n < LANES; n++) begin : g_lane
        logic [8:0] q_q = 9'h155;
        logic       rd_q = 1'b0;
        int         key;
        always @(negedge col_n_i[n]) begin
            #1;
            col_seen = 1'b1;
            key = int'({2'(n), row_q[n/2], addr_i});
            if ((n < 2) ? row_lo_n_i : row_hi_n_i)
                viol_o++;
            else if (!wr_n_i)
                mem[key] = {par_i[n], dq_i[8*n+:8]};
            else begin
                q_q = mem.exists(key) ? mem[key] : 9'h0A5;
                rd_q = 1'b1;
                if (dq_oe_i[n] || par_oe_i[n])
                    viol_o++;
            end
        end
        always @(posedge col_n_i[n]) begin
            rd_q = 1'b0;
        end
        // A floating lane shows the inverse of its last value.
        assign dq_o[8*n+:8] = dq_oe_i[n] ? dq_i[8*n+:8] :
                              rd_q ? q_q[7:0] : ~q_q[7:0];
        assign par_o[n] = par_oe_i[n] ? par_i[n] :
                          rd_q ? q_q[8] : ~q_q[8];
    end
endmodule
`default_nettype wire

// ==== test/dram_module_36bit_strobe_refresh_test.sv ====
/*
 * Self-checking bench for the DRAM host controller and a module model.
 * Assumes a 100 MHz clock and a shortened refresh interval of 50 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module dram_module_36bit_strobe_refresh_test;
    import dram_ctrl_pkg::*;
    localparam int unsigned INTERVAL = 50;
    logic ref_clk_i, nrst_i, req_i, we_i, ready_o, rvalid_o, rl_n, rh_n, ws_n;
    logic [ADDR_W-1:0] addr_i;
    logic [LANES-1:0]  lane_en_i, wpar_i, rpar_o, cs_n, dq_oe, mp_c, mp_oe;
    logic [LANES-1:0]  mp_m;
    logic [DATA_W-1:0] wdata_i, rdata_o, dq_c, dq_m;
    logic [MUX_W-1:0]  ma;
    int                viol, nref, max_gap, n_errors = 0, cmp_count = 0;
    dram_ctrl #(.REF_INTERVAL(INTERVAL)) dram_ctrl_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req_i), .we_i(we_i),
        .addr_i(addr_i), .lane_en_i(lane_en_i), .wdata_i(wdata_i),
        .wpar_i(wpar_i), .ready_o(ready_o), .rvalid_o(rvalid_o),
        .rdata_o(rdata_o), .rpar_o(rpar_o),
        .row_strobe_lower_half_n_o(rl_n), .row_strobe_upper_half_n_o(rh_n),
        .lane_column_strobes_n_o(cs_n), .write_strobe_n_o(ws_n),
        .multiplexed_addr_lines_o(ma), .shared_data_lines_i(dq_m),
        .shared_data_lines_o(dq_c), .shared_data_lines_oe_o(dq_oe),
        .lane_parity_lines_i(mp_m), .lane_parity_lines_o(mp_c),
        .lane_parity_lines_oe_o(mp_oe));
    dram_module_model dram_module_model_i (
        .row_lo_n_i(rl_n), .row_hi_n_i(rh_n), .col_n_i(cs_n), .wr_n_i(ws_n),
        .addr_i(ma), .dq_i(dq_c), .dq_oe_i(dq_oe), .par_i(mp_c),
        .par_oe_i(mp_oe), .dq_o(dq_m), .par_o(mp_m), .viol_o(viol),
        .nref_o(nref), .max_gap_o(max_gap));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [35:0] lmask(input logic [3:0] ln);
        logic [35:0] m;
        m = 36'h0_0000_0000;
        for (int n = 0; n < 4; n++)
            if (ln[n]) m = m | ({4'h1 << n, 32'hFF << (8 * n)});
        return m;
    endfunction
    // Holds the request until it is taken, then waits for the read data.
    task automatic access(input logic we, input logic [19:0] a,
                          input logic [3:0] ln, input logic [35:0] wd,
                          output logic [35:0] rd);
        int k;
        @(posedge ref_clk_i);
        req_i <= 1'b1;
        we_i <= we;
        addr_i <= a;
        lane_en_i <= ln;
        {wpar_i, wdata_i} <= wd;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (ready_o !== 1'b1 && k < 200);
        req_i <= 1'b0;
        rd = {rpar_o, rdata_o};
        if (!we) begin
            k = 0;
            do begin
                @(posedge ref_clk_i);
                k++;
            end while (rvalid_o !== 1'b1 && k < 200);
            rd = {rpar_o, rdata_o} & lmask(ln);
        end
        if (k >= 200) n_errors++;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    logic [19:0] adr [5] = '{20'h0_0000, 20'hF_FFFF, 20'h8_0000,
                             20'h0_0200, 20'h0_0401};
    task automatic t_reset;
        logic [35:0] pins;
        @(posedge ref_clk_i);
        pins = 36'({ready_o, rvalid_o, rl_n, rh_n, cs_n, ws_n, dq_oe, mp_oe});
        chk(pins, 36'h0_0001_7F00);
    endtask
    task automatic t_lanes;
        logic [35:0] rd;
        for (int i = 0; i < 5; i++)
            access(1'b1, adr[i], 4'hF, {4'(i), 32'hA5C3_0F00 ^ 32'(i)}, rd);
        for (int i = 0; i < 5; i++) begin
            access(1'b0, adr[i], 4'hF, 36'h0_0000_0000, rd);
            chk(rd, {4'(i), 32'hA5C3_0F00 ^ 32'(i)});
        end
    endtask
    task automatic t_mask;
        logic [35:0] rd, ex, m;
        ex = 36'h5_1234_5678;
        access(1'b1, 20'h1_2345, 4'hF, ex, rd);
        for (int n = 0; n < 4; n++) begin
            access(1'b1, 20'h1_2345, 4'h1 << n, 36'hA_EDCB_A987, rd);
            m = lmask(4'h1 << n);
            ex = (ex & ~m) | (36'hA_EDCB_A987 & m);
            access(1'b0, 20'h1_2345, 4'hF, 36'h0_0000_0000, rd);
            chk(rd, ex);
            access(1'b0, 20'h1_2345, 4'h1 << n, 36'h0_0000_0000, rd);
            chk(rd, ex & lmask(4'h1 << n));
        end
    endtask
    task automatic t_refresh;
        int k;
        int lim;
        lim = int'((ROWS + 1) * INTERVAL * CLK_NS);
        k = 0;
        while (nref <= int'(ROWS) && k < 60000) begin
            @(posedge ref_clk_i);
            k++;
        end
        chk(36'(nref > int'(ROWS)), 36'h1);
        chk(36'(max_gap <= lim), 36'h1);
        chk(36'(viol), 36'h0);
    endtask
    // ------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        {nrst_i, req_i, we_i, addr_i, lane_en_i, wdata_i, wpar_i} = '0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_lanes();
        t_mask();
        t_refresh();
        end_of_test();
    end
    initial begin
        #1_000_000;
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
